/* keypad_flags_pkg.sv */
// constants for the keypad row polarity and event flag bank
// assumes a plain strobe register port with 32-bit data
package keypad_flags_pkg;
    localparam logic [7:0] row_polarity_off = 8'h08;
    localparam logic [7:0] event_flags_off = 8'h0C;
    localparam logic [7:0] irq_enable_off = 8'h10;
    localparam logic [7:0] irq_clear_off = 8'h14;
    localparam logic [7:0] event_in_off = 8'h18;
    localparam int polarity_lsb = 16;
    localparam int row_count = 8;
    localparam int flag_count = 4;
    localparam int flag_manual_key = 0;
    localparam int flag_activity_scan = 1;
    localparam int flag_soft_scan = 2;
    localparam int flag_direct_input = 3;
    localparam logic [7:0] polarity_reset = 8'h00;
    localparam logic [3:0] flags_reset = 4'h0;
    localparam logic [3:0] enable_reset = 4'h0;
endpackage : keypad_flags_pkg

/* keypad_flags.sv */
// keypad row polarity register and sticky event flags with interrupt
// assumes scan engine pulses on the same clock; rows are raw pins
//
// How it works
// - eight polarity bits; a one makes that row active low
// - direct input detection sets status bit 3
// - flags stay set until software writes one to that bit
// - completed software-started matrix scan sets status bit 2
// - debounced activity-triggered scan sets status bit 1
// - key press during manual scan sets status bit 0
// - set flags are the interrupt sources
// - direct input enable gates the direct input interrupt request
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module keypad_flags (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // events from the scan engine, one-cycle pulses
    input wire logic direct_input_hit,
    input wire logic soft_scan_done,
    input wire logic activity_scan_done,
    input wire logic manual_key_hit,
    // keypad row pins and their polarity-corrected view
    input wire logic [7:0] row_pins,
    output logic [7:0] row_active,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic [7:0] polarity;
        logic [3:0] flags;
        logic [3:0] enable;
        logic [7:0] row_meta;
        logic [7:0] row_sync;
        logic [7:0] row_active;
        logic [31:0] rdata;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [3:0] events;
    logic [3:0] clear_mask;

    assign events = {direct_input_hit, soft_scan_done, activity_scan_done, manual_key_hit};

    always_comb begin
        s_d = s_q;
        clear_mask = 4'h0;
        // pins cross two flops before anything looks at them
        s_d.row_meta = row_pins;
        s_d.row_sync = s_q.row_meta;
        s_d.row_active = s_q.row_sync ^ s_q.polarity;
        if (reg_wr) begin
            unique case (reg_addr)
                keypad_flags_pkg::row_polarity_off: begin
                    s_d.polarity = reg_wdata[keypad_flags_pkg::polarity_lsb +: 8];
                end
                keypad_flags_pkg::event_flags_off,
                keypad_flags_pkg::irq_clear_off: begin
                    clear_mask = reg_wdata[3:0];
                end
                keypad_flags_pkg::irq_enable_off: begin
                    s_d.enable = reg_wdata[3:0];
                end
                default: begin
                end
            endcase
        end
        // set after clear so a same-cycle event survives
        s_d.flags = (s_q.flags & ~clear_mask) | events;
        // enabled flags drive the one interrupt line
        s_d.irq = |(s_d.flags & s_d.enable);
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                keypad_flags_pkg::row_polarity_off: begin
                    s_d.rdata[keypad_flags_pkg::polarity_lsb +: 8] = s_q.polarity;
                end
                keypad_flags_pkg::event_flags_off: begin
                    s_d.rdata[3:0] = s_q.flags;
                end
                keypad_flags_pkg::irq_enable_off: begin
                    s_d.rdata[3:0] = s_q.enable;
                end
                keypad_flags_pkg::event_in_off: begin
                    s_d.rdata[7:0] = s_q.row_active;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.polarity <= keypad_flags_pkg::polarity_reset;
            s_q.flags <= keypad_flags_pkg::flags_reset;
            s_q.enable <= keypad_flags_pkg::enable_reset;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign row_active = s_q.row_active;
    assign irq = s_q.irq;

    sequence s_direct_pulse;
        direct_input_hit;
    endsequence

    property p_direct_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        s_direct_pulse |=> s_q.flags[3];
    endproperty
    a_direct_sets: assert property (p_direct_sets) else $error("direct flag not set");

    property p_soft_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        soft_scan_done |=> s_q.flags[2];
    endproperty
    a_soft_sets: assert property (p_soft_sets) else $error("soft scan flag not set");

    property p_activity_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        activity_scan_done |=> s_q.flags[1];
    endproperty
    a_activity_sets: assert property (p_activity_sets) else $error("activity flag not set");

    property p_manual_sets;
        @(posedge sys_clk) disable iff (!rst_n)
        manual_key_hit |=> s_q.flags[0];
    endproperty
    a_manual_sets: assert property (p_manual_sets) else $error("manual flag not set");

    property p_flag_sticky;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_q.flags[0] && !(reg_wr && reg_wdata[0]
            && (reg_addr == 8'h0C || reg_addr == 8'h14))) |=> s_q.flags[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

    property p_clear_works;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h0C && reg_wdata[3] && !direct_input_hit) |=> !s_q.flags[3];
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("write one did not clear");

    // set and clear on one edge: the event must survive the clear
    property p_set_wins;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h0C && reg_wdata[3] && direct_input_hit) |=> s_q.flags[3];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_irq_follows;
        @(posedge sys_clk) disable iff (!rst_n)
        ##1 (irq == |(s_q.flags & s_q.enable));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

    property p_direct_irq_masked;
        @(posedge sys_clk) disable iff (!rst_n)
        (!s_q.enable[3] && s_q.flags[2:0] == 3'h0) |-> !irq || $past(s_q.enable[3]) || $past(|s_q.flags);
    endproperty
    a_direct_irq_masked: assert property (p_direct_irq_masked) else $error("masked irq raised");

    property p_polarity;
        @(posedge sys_clk) disable iff (!rst_n)
        $stable(s_q.polarity) |=> row_active == ($past(s_q.row_sync) ^ $past(s_q.polarity));
    endproperty
    a_polarity: assert property (p_polarity) else $error("row polarity wrong");

    // every flag, not only bit 0, holds until a write of one reaches it
    for (genvar f = 0; f < keypad_flags_pkg::flag_count; f++) begin : g_flag_held
        property p_flag_held;
            @(posedge sys_clk) disable iff (!rst_n)
            (s_q.flags[f] && !(reg_wr && reg_wdata[f]
                && (reg_addr == 8'h0C || reg_addr == 8'h14))) |=> s_q.flags[f];
        endproperty
        a_flag_held: assert property (p_flag_held) else $error("flag dropped");
    end

    // no event and no clear: a clear flag stays clear
    property p_flag_no_spurious;
        @(posedge sys_clk) disable iff (!rst_n)
        (!s_q.flags[3] && !direct_input_hit) |=> !s_q.flags[3];
    endproperty
    a_flag_no_spurious: assert property (p_flag_no_spurious) else $error("flag set alone");

    // reset leaves every output low on the next edge
    property p_reset_quiet;
        @(posedge sys_clk)
        !rst_n |=> (irq == 1'b0 && reg_rdata == 32'h0000_0000 && row_active == 8'h00);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output set in reset");

    // read data stand for one cycle only; zero otherwise
    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
endmodule : keypad_flags

/* keypad_rows_model.sv */
// keypad model: switches wired onto the row pins
// assumes each row idles at its released level through a pull
`timescale 1ns/1ps
module keypad_rows_model (
    // key state and wiring
    input wire logic [7:0] key_down,
    input wire logic [7:0] wired_low,
    // row pins
    output logic [7:0] row_pins
);
    // a low-wired row idles high and is pulled low by its key
    assign row_pins = key_down ^ wired_low;
endmodule : keypad_rows_model

/* keypad_flags_test.sv */
// bench for the keypad polarity register and event flags
// assumes the keypad model on the rows and one 25 MHz clock
`timescale 1ns/1ps
`define chk(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module keypad_flags_test;
    logic sys_clk = 0;
    logic rst_n = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [31:0] reg_rdata;
    logic [3:0] ev = 4'h0;
    logic [7:0] row_pins, key_down = 8'h00, pol = 8'h00, row_active;
    logic irq, pend = 0;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    int errors = 0, n_compared = 0, seed = 74;
    always #20 sys_clk = ~sys_clk;
    keypad_rows_model keypad_rows_model_inst (.key_down(key_down), .wired_low(pol),
        .row_pins(row_pins));
    keypad_flags keypad_flags_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .direct_input_hit(ev[3]), .soft_scan_done(ev[2]), .activity_scan_done(ev[1]),
        .manual_key_hit(ev[0]), .row_pins(row_pins), .row_active(row_active), .irq(irq));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        reg_rd <= 1; reg_addr <= a; exp_q.push_back(x);
        @(posedge sys_clk);
        reg_rd <= 0;
    endtask : rd
    task automatic pulse(input int i);
        @(posedge sys_clk);
        ev <= 4'h1 << i;
        @(posedge sys_clk);
        ev <= 4'h0;
    endtask : pulse
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) pend <= reg_rd;
    always @(negedge sys_clk) begin
        if (pend) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("unexpected %0t read data with no note", $time);
            end else begin
                e = exp_q.pop_front();
                `chk(reg_rdata, e)
            end
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1;
        rd(keypad_flags_pkg::row_polarity_off, 32'h0);
        rd(keypad_flags_pkg::event_flags_off, 32'h0);
        rd(8'h04, 32'h0);
        $display("reset test done");
        // random wiring; junk in reserved bits must not stick
        pol <= 8'($random(seed));
        key_down <= 8'($random(seed));
        @(posedge sys_clk);
        wr(keypad_flags_pkg::row_polarity_off, {8'hFF, pol, 16'hFFFF});
        rd(keypad_flags_pkg::row_polarity_off, {8'h00, pol, 16'h0000});
        repeat (4) @(posedge sys_clk);
        rd(keypad_flags_pkg::event_in_off, {24'h0, key_down});
        $display("polarity test done");
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            rd(keypad_flags_pkg::event_flags_off, (32'h2 << i) - 32'h1);
        end
        wr(keypad_flags_pkg::irq_enable_off, 32'h8);
        @(negedge sys_clk);
        `chk(irq, 1'b1)
        wr(keypad_flags_pkg::event_flags_off, 32'h8);
        @(negedge sys_clk);
        `chk(irq, 1'b0)
        wr(keypad_flags_pkg::irq_enable_off, 32'hF);
        rd(keypad_flags_pkg::irq_enable_off, 32'hF);
        @(negedge sys_clk);
        `chk(irq, 1'b1)
        wr(keypad_flags_pkg::irq_clear_off, 32'h7);
        @(negedge sys_clk);
        `chk(irq, 1'b0)
        $display("interrupt test done");
        // event and clear land on the same edge
        fork
            pulse(3);
            wr(keypad_flags_pkg::event_flags_off, 32'h8);
        join
        rd(keypad_flags_pkg::event_flags_off, 32'h8);
        @(negedge sys_clk);
        `chk(irq, 1'b1)
        $display("collision test done");
        repeat (2) @(posedge sys_clk);
        give_verdict();
    end
endmodule : keypad_flags_test
